/* logic/cfg_seq_pkg.sv */
package cfg_seq_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS     = 5;
	localparam int CFG_CLK_PERIOD_NS = 20;
	localparam int CFG_DIV           = (CFG_CLK_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CLEAR_CFG_CYCLES  = 16;

	// ****************************************
	// sizes
	// ****************************************
	localparam int DATA_W     = 32;
	localparam int FIFO_DEPTH = 4;
	localparam int BITS_W     = 23;
	localparam int WORDS_W    = 18;
	localparam int N_DLL      = 4;
	localparam int STAGE_W    = 3;
	localparam int N_PIN      = 3 + N_DLL;

	// smallest 559,200 bits, largest 6,127,744 bits
	localparam logic [BITS_W-1:0] BITS_MIN = 23'h088860;
	localparam logic [BITS_W-1:0] BITS_MAX = 23'h5D8080;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STARTUP = 8'h04;
	localparam logic [7:0] OFS_BITS    = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;
	localparam logic [7:0] OFS_LOADED  = 8'h10;
	localparam logic [7:0] OFS_RB_ADDR = 8'h14;
	localparam logic [7:0] OFS_RB_CMD  = 8'h18;
	localparam logic [7:0] OFS_RB_DATA = 8'h1C;

	// ****************************************
	// fields
	// ****************************************
	localparam int CTRL_RESTART   = 0;
	localparam int CTRL_SYNC_DONE = 1;
	localparam int CTRL_DLL_WAIT  = 2;
	localparam int SU_FLOAT_LSB   = 0;
	localparam int SU_FORCE_LSB   = 4;
	localparam int SU_WRITE_LSB   = 8;
	localparam int SU_DLL_LSB     = 12;
	localparam int SU_MASK_LSB    = 16;
	localparam int SU_DLL_ALL     = 20;
	localparam int RB_CMD_GO      = 0;
	localparam int RB_CMD_STATE   = 1;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] CTRL_RST    = 32'h00000000;
	localparam logic [31:0] STARTUP_RST = 32'h000F0221;
	localparam logic [31:0] BITS_RST    = {9'h000, BITS_MIN};
	localparam logic [N_PIN-1:0] PIN_RST = 7'h05;
	localparam logic [STAGE_W-1:0] LAST_STAGE = 3'h7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [4:0] {
		PH_CLEAR     = 5'h01,
		PH_WAIT_INIT = 5'h02,
		PH_LOAD      = 5'h04,
		PH_STARTUP   = 5'h08,
		PH_RUN       = 5'h10
	} phase_e;

endpackage : cfg_seq_pkg

/* logic/frame_fifo.sv */
module frame_fifo
	import cfg_seq_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             flush,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH)) && !flush;
	assign out_valid = (count_reg != '0) && !flush;
	assign out_data  = mem_reg[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge aclk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
					: wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
					: rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule : frame_fifo

/* logic/config_delay_startup_sequencer.sv */
// Our own choices: the placing of the registers and the AXI4-Lite register port.
module config_delay_startup_sequencer
	import cfg_seq_pkg::*;
(
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write address
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [7:0]            s_axi_awaddr,
	// axi4-lite write data
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	// axi4-lite write response
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output logic [1:0]                 s_axi_bresp,
	// axi4-lite read
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [7:0]            s_axi_araddr,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	// open-drain clear-status pin
	input  wire logic                  init_in,
	output logic                       init_out,
	output logic                       init_oe,
	// open-drain completion pin
	input  wire logic                  done_in,
	output logic                       done_out,
	output logic                       done_oe,
	// reconfiguration request and loop lock pins
	input  wire logic                  prog_n,
	input  wire logic [N_DLL-1:0]      dll_locked,
	// configuration data stream
	input  wire logic                  data_valid,
	output logic                       data_ready,
	input  wire logic [DATA_W-1:0]     data_word,
	// configuration memory write port
	output logic                       cfg_wr_valid,
	input  wire logic                  cfg_wr_ready,
	output logic [WORDS_W-1:0]         cfg_wr_addr,
	output logic [DATA_W-1:0]          cfg_wr_data,
	// readback port
	output logic                       rb_req,
	output logic                       rb_capture,
	output logic [31:0]                rb_addr,
	input  wire logic                  rb_ack,
	input  wire logic [31:0]           rb_data,
	// global start-up controls
	output logic                       global_output_float,
	output logic                       global_state_force,
	output logic                       global_store_write_en
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [N_PIN-1:0] pin_raw;
	logic [N_PIN-1:0] s1_reg;
	logic [N_PIN-1:0] s2_reg;
	logic [N_PIN-1:0] s3_reg;
	logic [N_PIN-1:0] pin_reg;

	assign pin_raw = {dll_locked, prog_n, done_in, init_in};

	for (genvar g = 0; g < N_PIN; g++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s1_reg[g]  <= PIN_RST[g];
				s2_reg[g]  <= PIN_RST[g];
				s3_reg[g]  <= PIN_RST[g];
				pin_reg[g] <= PIN_RST[g];
			end else begin
				s1_reg[g] <= pin_raw[g];
				s2_reg[g] <= s1_reg[g];
				s3_reg[g] <= s2_reg[g];
				// glitch filter: two stages must agree
				if (s2_reg[g] == s3_reg[g]) begin
					pin_reg[g] <= s3_reg[g];
				end
			end
		end
	end

	logic             init_high;
	logic             done_high;
	logic             prog_low;
	logic [N_DLL-1:0] lock_now;

	assign init_high = pin_reg[0];
	assign done_high = pin_reg[1];
	assign prog_low  = !pin_reg[2];
	assign lock_now  = pin_reg[N_PIN-1:3];

	// ****************************************
	// config clock enable
	// ****************************************
	logic [7:0] div_reg;
	logic       tick;

	assign tick = (div_reg == 8'(CFG_DIV - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// ****************************************
	// register bus
	// ****************************************
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [7:0]        aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              wr_fire;
	logic [31:0]       ctrl_reg;
	logic [31:0]       startup_reg;
	logic [31:0]       bits_reg;
	logic [31:0]       rb_addr_reg;
	logic [31:0]       rb_data_reg;
	logic              rb_busy_reg;
	logic              restart_reg;
	phase_e            phase_reg;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : merge

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready  = !w_held_reg;
	assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr_reg[1:0] == 2'h0
				&& aw_addr_reg <= OFS_RB_DATA) ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// bit count locked while loading so the target cannot move
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg    <= CTRL_RST;
			startup_reg <= STARTUP_RST;
			bits_reg    <= BITS_RST;
			rb_addr_reg <= '0;
		end else if (wr_fire) begin
			case (aw_addr_reg)
				OFS_CTRL: ctrl_reg <= merge(ctrl_reg, w_data_reg,
					w_strb_reg) & 32'h00000006;
				OFS_STARTUP: startup_reg <= merge(startup_reg, w_data_reg,
					w_strb_reg) & 32'h001F7777;
				OFS_BITS: if (phase_reg != PH_LOAD) begin
					bits_reg <= merge(bits_reg, w_data_reg, w_strb_reg)
						& {9'h000, {BITS_W{1'b1}}};
				end
				OFS_RB_ADDR: rb_addr_reg <= merge(rb_addr_reg, w_data_reg,
					w_strb_reg);
				default: ;
			endcase
		end
	end

	logic ctrl_hit;
	assign ctrl_hit = wr_fire && aw_addr_reg == OFS_CTRL && w_strb_reg[0];

	// ****************************************
	// restart and phase sequencing
	// ****************************************
	logic                restart;
	logic [7:0]          clr_cnt_reg;
	logic [WORDS_W-1:0]  words_in_reg;
	logic [WORDS_W-1:0]  words_out_reg;
	logic [WORDS_W-1:0]  total_words;
	logic                load_complete;
	logic [STAGE_W-1:0]  stage_reg;
	logic                sync_ok;
	logic                lock_ok;
	logic                advance;
	logic [N_DLL-1:0]    dll_mask;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= ctrl_hit && w_data_reg[CTRL_RESTART];
		end
	end

	assign restart     = prog_low || restart_reg;
	assign total_words = bits_reg[BITS_W-1:5];
	assign load_complete = words_out_reg == total_words && !cfg_wr_valid;
	assign sync_ok = !ctrl_reg[CTRL_SYNC_DONE] || done_high;
	assign dll_mask = startup_reg[SU_DLL_ALL] ? '1
		: startup_reg[SU_MASK_LSB +: N_DLL];
	assign lock_ok = &(lock_now | ~dll_mask);
	assign advance = sync_ok && (!ctrl_reg[CTRL_DLL_WAIT] || lock_ok
		|| stage_reg != startup_reg[SU_DLL_LSB +: STAGE_W]);

	// clear -> wait for init -> load -> start-up -> run, restarting from reset as well
	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			phase_reg <= PH_CLEAR;
		end else begin
			case (phase_reg)
				PH_CLEAR: if (tick
					&& clr_cnt_reg == 8'(CLEAR_CFG_CYCLES - 1)) begin
					phase_reg <= PH_WAIT_INIT;
				end
				PH_WAIT_INIT: if (init_high) begin
					phase_reg <= PH_LOAD;
				end
				PH_LOAD: if (load_complete) begin
					phase_reg <= PH_STARTUP;
				end
				PH_STARTUP: if (tick && advance
					&& stage_reg == LAST_STAGE) begin
					phase_reg <= PH_RUN;
				end
				PH_RUN: phase_reg <= PH_RUN;
				default: phase_reg <= PH_CLEAR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || phase_reg != PH_CLEAR || restart) begin
			clr_cnt_reg <= '0;
		end else if (tick) begin
			clr_cnt_reg <= clr_cnt_reg + 1'b1;
		end
	end

	assign init_out = 1'b0;
	assign init_oe  = (phase_reg == PH_CLEAR);
	assign done_out = 1'b0;
	assign done_oe  = !(phase_reg == PH_STARTUP || phase_reg == PH_RUN);

	// ****************************************
	// data path into configuration memory
	// ****************************************
	logic              fifo_in_ready;
	logic              fifo_in_valid;
	logic              fifo_out_valid;
	logic              fifo_out_ready;
	logic [DATA_W-1:0] fifo_out_data;
	logic              accepting;

	assign accepting     = phase_reg == PH_LOAD && words_in_reg < total_words;
	assign fifo_in_valid = data_valid && accepting;
	assign data_ready    = fifo_in_ready && accepting;
	// one word per config clock cycle
	assign fifo_out_ready = phase_reg == PH_LOAD && tick
		&& !cfg_wr_valid;

	frame_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.flush    (restart),
		.in_valid (fifo_in_valid),
		.in_ready (fifo_in_ready),
		.in_data  (data_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data (fifo_out_data)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			words_in_reg  <= '0;
			words_out_reg <= '0;
			cfg_wr_valid  <= 1'b0;
			cfg_wr_addr   <= '0;
			cfg_wr_data   <= '0;
		end else begin
			if (fifo_in_valid && fifo_in_ready) begin
				words_in_reg <= words_in_reg + 1'b1;
			end
			if (fifo_out_valid && fifo_out_ready) begin
				cfg_wr_valid <= 1'b1;
				cfg_wr_addr  <= words_out_reg;
				cfg_wr_data  <= fifo_out_data;
			end else if (cfg_wr_ready) begin
				cfg_wr_valid <= 1'b0;
			end
			if (cfg_wr_valid && cfg_wr_ready) begin
				words_out_reg <= words_out_reg + 1'b1;
			end
		end
	end

	// ****************************************
	// start-up sequence
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn || phase_reg != PH_STARTUP) begin
			if (!aresetn || phase_reg != PH_RUN) begin
				stage_reg <= '0;
			end
		end else if (tick && advance && stage_reg != LAST_STAGE) begin
			stage_reg <= stage_reg + 1'b1;
		end
	end

	// sticky releases: nothing re-asserts them short of a restart
	always_ff @(posedge aclk) begin
		if (!aresetn || restart || phase_reg == PH_CLEAR) begin
			global_output_float   <= 1'b1;
			global_state_force    <= 1'b1;
			global_store_write_en <= 1'b0;
		end else if (phase_reg == PH_STARTUP && sync_ok) begin
			if (stage_reg >= startup_reg[SU_FLOAT_LSB +: STAGE_W]) begin
				global_output_float <= 1'b0;
			end
			if (stage_reg >= startup_reg[SU_FORCE_LSB +: STAGE_W]) begin
				global_state_force <= 1'b0;
			end
			if (stage_reg >= startup_reg[SU_WRITE_LSB +: STAGE_W]) begin
				global_store_write_en <= 1'b1;
			end
		end
	end

	// ****************************************
	// readback
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rb_busy_reg <= 1'b0;
			rb_req      <= 1'b0;
			rb_capture  <= 1'b0;
			rb_addr     <= '0;
			rb_data_reg <= '0;
		end else begin
			rb_req <= 1'b0;
			if (!rb_busy_reg && wr_fire && aw_addr_reg == OFS_RB_CMD
				&& w_strb_reg[0] && w_data_reg[RB_CMD_GO]) begin
				rb_busy_reg <= 1'b1;
				rb_req      <= 1'b1;
				rb_capture  <= w_data_reg[RB_CMD_STATE];
				rb_addr     <= rb_addr_reg;
			end else if (rb_busy_reg && rb_ack) begin
				rb_busy_reg <= 1'b0;
				rb_data_reg <= rb_data;
			end
		end
	end

	// ****************************************
	// register read
	// ****************************************
	logic [31:0] status;
	logic [31:0] rd_mux;
	logic        rd_hit;

	assign status = {12'h000, lock_now, 1'b0, stage_reg, 1'b0, rb_busy_reg,
		global_store_write_en, global_state_force, global_output_float,
		done_high, init_high, phase_reg};

	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			OFS_CTRL:    rd_mux = ctrl_reg;
			OFS_STARTUP: rd_mux = startup_reg;
			OFS_BITS:    rd_mux = bits_reg;
			OFS_STATUS:  rd_mux = status;
			OFS_LOADED:  rd_mux = {14'h0000, words_out_reg};
			OFS_RB_ADDR: rd_mux = rb_addr_reg;
			OFS_RB_CMD:  rd_mux = {31'h00000000, rb_busy_reg};
			OFS_RB_DATA: rd_mux = rb_data_reg;
			default: begin
				rd_mux = '0;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : config_delay_startup_sequencer

/* dv/cfg_seq_props.sv */
module cfg_seq_props
	import cfg_seq_pkg::*;
(
	// clock and reset
	input wire logic               aclk,
	input wire logic               aresetn,
	// pins and streams
	input wire logic               init_oe,
	input wire logic               done_oe,
	input wire logic               data_ready,
	input wire logic               cfg_wr_valid,
	input wire logic               cfg_wr_ready,
	input wire logic [WORDS_W-1:0] cfg_wr_addr,
	input wire logic [DATA_W-1:0]  cfg_wr_data,
	input wire logic               rb_req,
	input wire logic               rb_ack,
	// start-up controls
	input wire logic               global_output_float,
	input wire logic               global_state_force,
	input wire logic               global_store_write_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************
	// clear length
	// ****************
	logic [7:0] clr_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn || !init_oe) clr_cnt <= 8'h00;
		else if (clr_cnt != 8'hFF) clr_cnt <= clr_cnt + 8'h01;
	end

	clear_length_a: assert property (
		$fell(init_oe) |-> clr_cnt >= 8'h3C) else $error("clear too short");
	load_gate_a: assert property (
		data_ready |-> !init_oe && done_oe) else $error("data taken early");
	write_phase_a: assert property (
		cfg_wr_valid |-> !init_oe && done_oe) else $error("write off phase");
	frame_hold_a: assert property (
		cfg_wr_valid && !cfg_wr_ready |=> cfg_wr_valid
		&& $stable(cfg_wr_addr) && $stable(cfg_wr_data))
		else $error("frame write dropped");
	float_release_a: assert property (
		$fell(global_output_float) |-> !done_oe && !init_oe)
		else $error("float released early");
	force_release_a: assert property (
		$fell(global_state_force) |-> !done_oe) else $error("force early");
	write_release_a: assert property (
		$rose(global_store_write_en) |-> !done_oe) else $error("wen early");
	controls_sticky_a: assert property (
		$rose(global_output_float) |-> ##[0:2] init_oe)
		else $error("float returned without restart");
	readback_pulse_a: assert property (
		rb_req |=> !rb_req) else $error("readback request too long");

	cover property ($fell(global_output_float));
	cover property (cfg_wr_valid && !cfg_wr_ready);
	cover property (rb_ack);
endmodule : cfg_seq_props

bind config_delay_startup_sequencer cfg_seq_props u_props (
	.aclk(aclk), .aresetn(aresetn), .init_oe(init_oe), .done_oe(done_oe),
	.data_ready(data_ready), .cfg_wr_valid(cfg_wr_valid),
	.cfg_wr_ready(cfg_wr_ready), .cfg_wr_addr(cfg_wr_addr),
	.cfg_wr_data(cfg_wr_data), .rb_req(rb_req), .rb_ack(rb_ack),
	.global_output_float(global_output_float),
	.global_state_force(global_state_force),
	.global_store_write_en(global_store_write_en));

/* dv/far_side_model.sv */
module far_side_model
	import cfg_seq_pkg::*;
(
	// clock and reset
	input wire logic               aclk,
	input wire logic               aresetn,
	// bench controls
	input wire logic               hold_init,
	input wire logic               hold_done,
	input wire logic               slow,
	// wired pins
	input wire logic               init_oe,
	output logic                   init_in,
	input wire logic               done_oe,
	output logic                   done_in,
	// memory write port
	input wire logic               cfg_wr_valid,
	output logic                   cfg_wr_ready,
	input wire logic [WORDS_W-1:0] cfg_wr_addr,
	input wire logic [DATA_W-1:0]  cfg_wr_data,
	output int                     words,
	output int                     bad,
	// readback port
	input wire logic               rb_req,
	input wire logic               rb_capture,
	input wire logic [31:0]        rb_addr,
	output logic                   rb_ack,
	output logic [31:0]            rb_data
);
	logic [1:0]  cnt;
	logic [2:0]  rb_wait;
	logic [31:0] rb_val;

	// pull-ups; outside parties only ever pull low
	assign init_in = !(init_oe || hold_init);
	assign done_in = !(done_oe || hold_done);
	// slow memory takes one word in four cycles
	assign cfg_wr_ready = !slow || cnt == 2'h2;
	assign rb_val = rb_addr + 32'h00000100 + {31'h0, rb_capture};
	// idle bus shows the inverse, never a held value
	assign rb_data = rb_ack ? rb_val : ~rb_val;
	assign rb_ack = rb_wait == 3'h1;

	always_ff @(posedge aclk) cnt <= aresetn ? cnt + 2'h1 : 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) rb_wait <= 3'h0;
		else if (rb_req) rb_wait <= 3'h3;
		else if (rb_wait != 3'h0) rb_wait <= rb_wait - 3'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || init_oe) begin
			words <= 0;
			bad <= 0;
		end else if (cfg_wr_valid && cfg_wr_ready) begin
			words <= words + 1;
			if (cfg_wr_addr !== WORDS_W'(words)
				|| cfg_wr_data !== 32'hC0DE0000 + words) bad <= bad + 1;
		end
	end
endmodule : far_side_model

/* dv/config_delay_startup_sequencer_test.sv */
module config_delay_startup_sequencer_test
	import cfg_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic              aclk = 1'b0, aresetn = 1'b0, prog_n = 1'b1;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0, data_valid = 1'b0;
	logic              hold_init = 1'b1, hold_done = 1'b0, slow = 1'b1;
	logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]       wdata = 32'h0, data_word = 32'h0;
	logic [N_DLL-1:0]  dll_locked = 4'h0;
	logic              awready, wready, bvalid, arready, rvalid, rb_ack;
	logic              init_oe, done_oe, init_in, done_in, data_ready;
	logic              cfg_wr_valid, cfg_wr_ready, rb_req, rb_capture;
	logic              flt, frc, wen;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata, rb_addr, rb_data, rd_val;
	logic [WORDS_W-1:0] cfg_wr_addr;
	logic [DATA_W-1:0] cfg_wr_data;
	int                fails = 0, compares = 0, words, bad, n;

	always #2.5 aclk = ~aclk;

	config_delay_startup_sequencer dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .init_in(init_in),
		.init_out(), .init_oe(init_oe), .done_in(done_in), .done_out(),
		.done_oe(done_oe), .prog_n(prog_n), .dll_locked(dll_locked),
		.data_valid(data_valid), .data_ready(data_ready),
		.data_word(data_word), .cfg_wr_valid(cfg_wr_valid),
		.cfg_wr_ready(cfg_wr_ready), .cfg_wr_addr(cfg_wr_addr),
		.cfg_wr_data(cfg_wr_data), .rb_req(rb_req), .rb_capture(rb_capture),
		.rb_addr(rb_addr), .rb_ack(rb_ack), .rb_data(rb_data),
		.global_output_float(flt), .global_state_force(frc),
		.global_store_write_en(wen));

	far_side_model u_far (.aclk(aclk), .aresetn(aresetn),
		.hold_init(hold_init), .hold_done(hold_done), .slow(slow),
		.init_oe(init_oe), .init_in(init_in), .done_oe(done_oe),
		.done_in(done_in), .cfg_wr_valid(cfg_wr_valid),
		.cfg_wr_ready(cfg_wr_ready), .cfg_wr_addr(cfg_wr_addr),
		.cfg_wr_data(cfg_wr_data), .words(words), .bad(bad),
		.rb_req(rb_req), .rb_capture(rb_capture), .rb_addr(rb_addr),
		.rb_ack(rb_ack), .rb_data(rb_data));

	// ****************
	// helpers
	// ****************
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done

	task guard(input int k);
		if (k >= 2000) begin
			chk(32'h0, 32'h1);
			test_done;
		end
	endtask : guard

	// 0 done_oe, 1 float, 2 force, 3 write enable
	function logic pick(input int i);
		case (i)
			0: return done_oe;
			1: return flt;
			2: return frc;
			default: return wen;
		endcase
	endfunction : pick

	task waitv(input int i, input logic v);
		n = 0;
		while (pick(i) !== v && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		guard(n);
	endtask : waitv

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int k;
		k = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && k < 2000);
		guard(k);
		chk(bresp, e);
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task rd(input logic [7:0] a, input logic [1:0] e);
		int k;
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && k < 2000);
		guard(k);
		rd_val = rdata;
		chk(rresp, e);
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	// valid stays up across words, so it is never rewritten in one step
	task load(input int cnt);
		int k;
		for (int i = 0; i < cnt; i++) begin
			data_word <= 32'hC0DE0000 + i;
			data_valid <= 1'b1;
			k = 0;
			do begin
				@(posedge aclk);
				k++;
			end while (data_ready !== 1'b1 && k < 2000);
			guard(k);
		end
		data_valid <= 1'b0;
	endtask : load

	// ****************
	// tests
	// ****************
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_STARTUP, RESP_OKAY);
		chk(rd_val, STARTUP_RST);
		rd(OFS_BITS, RESP_OKAY);
		chk(rd_val, BITS_RST);
		rd(8'h20, RESP_DECERR);
		chk(rd_val, 32'h0);
		wr(8'h20, 32'hFFFFFFFF, RESP_DECERR);
		wr(OFS_BITS, 32'h000000C0, RESP_OKAY);
		rd(OFS_BITS, RESP_OKAY);
		chk(rd_val, 32'h000000C0);
		$display("test registers done");
		repeat (100) @(posedge aclk);
		rd(OFS_STATUS, RESP_OKAY);
		chk(rd_val & 32'h3F, 32'h02);
		chk(data_ready, 1'b0);
		hold_init <= 1'b0;
		load(6);
		waitv(0, 1'b0);
		chk(words, 6);
		chk(bad, 0);
		waitv(1, 1'b0);
		chk(n >= 1 && n <= CFG_DIV + 1, 1'b1);
		waitv(2, 1'b0);
		chk(n, CFG_DIV);
		chk(wen, 1'b1);
		chk(data_ready, 1'b0);
		$display("test default start-up done");
		hold_init <= 1'b1;
		hold_done <= 1'b1;
		prog_n <= 1'b0;
		repeat (5) @(posedge aclk);
		prog_n <= 1'b1;
		repeat (8) @(posedge aclk);
		chk({flt, frc, wen}, 3'b110);
		wr(OFS_STARTUP, 32'h00012314, RESP_OKAY);
		wr(OFS_CTRL, 32'h00000006, RESP_OKAY);
		hold_init <= 1'b0;
		load(6);
		waitv(0, 1'b0);
		repeat (40) @(posedge aclk);
		chk({flt, frc}, 2'b11);
		hold_done <= 1'b0;
		waitv(2, 1'b0);
		repeat (40) @(posedge aclk);
		chk({flt, wen}, 2'b10);
		dll_locked <= 4'h1;
		waitv(3, 1'b1);
		chk(flt, 1'b1);
		waitv(1, 1'b0);
		repeat (60) @(posedge aclk);
		chk({flt, frc, wen}, 3'b001);
		rd(OFS_STATUS, RESP_OKAY);
		chk(rd_val & 32'h1F, 32'h10);
		$display("test synced stalled start-up done");
		wr(OFS_RB_ADDR, 32'h00000040, RESP_OKAY);
		wr(OFS_RB_CMD, 32'h00000003, RESP_OKAY);
		n = 0;
		do begin
			rd(OFS_RB_CMD, RESP_OKAY);
			n++;
		end while (rd_val[0] !== 1'b0 && n < 2000);
		guard(n);
		rd(OFS_RB_DATA, RESP_OKAY);
		chk(rd_val, 32'h00000141);
		$display("test readback done");
		wr(OFS_CTRL, 32'h00000007, RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk({flt, frc, wen, init_oe}, 4'b1101);
		rd(OFS_CTRL, RESP_OKAY);
		chk(rd_val, 32'h00000006);
		$display("test restart done");
		test_done;
	end

	initial begin
		repeat (60000) @(posedge aclk);
		chk(32'h0, 32'h1);
		test_done;
	end
endmodule : config_delay_startup_sequencer_test
